// ### pkg/fph_defines.svh
// Constants for the fast programming command handler
`ifndef FPH_DEFINES_SVH
`define FPH_DEFINES_SVH

// Handshake phase codes on the mode lines
`define FPH_MODE_CMD 4'h1
`define FPH_MODE_ADDR_PHASE_0 4'h2
`define FPH_MODE_ADDR_PHASE_1 4'h3
`define FPH_MODE_ADDR_PHASE_2 4'h4
`define FPH_MODE_ADDR_PHASE_3 4'h5
`define FPH_MODE_DATA 4'h6

// Opcode table
`define FPH_OP_PAGE_WRITE 8'h01
`define FPH_OP_PAGE_WRITE_LOCK 8'h02
`define FPH_OP_ERASE_PAGE_WRITE 8'h03
`define FPH_OP_ERASE_PAGE_WRITE_LOCK 8'h04
`define FPH_OP_ERASE_ALL 8'h08
`define FPH_OP_SET_LOCK 8'h0f
`define FPH_OP_CLEAR_LOCK 8'h10
`define FPH_OP_GET_LOCK 8'h12
`define FPH_OP_SET_NV 8'h0b
`define FPH_OP_CLEAR_NV 8'h0d
`define FPH_OP_GET_NV 8'h0e
`define FPH_OP_SET_SECURE 8'h11
`define FPH_OP_PICK_CTRL 8'h34
`define FPH_OP_MEM_WRITE 8'h1f
`define FPH_OP_GET_VERSION 8'h1e

// Controller select values carried in the data phase
`define FPH_SEL_ZERO 16'h0000
`define FPH_SEL_ONE 16'h0001

// Erase pin hold time
`define FPH_ERASE_HOLD_MS 220
`define FPH_CLK_KHZ 125000
`define FPH_ERASE_HOLD_CYC (`FPH_ERASE_HOLD_MS * `FPH_CLK_KHZ + 1)

`endif

// ### pkg/fph_pkg.sv
// Types for the fast programming command handler
package fph_pkg;

  typedef enum logic [2:0] {
    FPH_ER_IDLE = 3'b001,
    FPH_ER_HOLD = 3'b010,
    FPH_ER_WAIT = 3'b100
  } fph_erase_t;

endpackage

// ### core/fph_cmd.sv
// Fast programming command handler with its write FIFO
//
// Overview of operation
// - Set-flags mask ones activate configuration bits
// - Clear-flags mask ones deactivate bits
// - Erase-all also clears all configuration bits
// - Get-flags read returns configuration bit mask
// - Security active refuses every further command
// - Long erase pin hold, test low, erases
// - Security clears only after flash erased
// - Controller zero after reset; data selects
// - Flash commands go to selected controller
// - Memory write takes address phases then data
// - Data writes store then bump address
// - Get-version read returns interface version
// - Command phase ends chain, flushes load
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`include "fph_defines.svh"

module fph_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fph_fifo_st_t;

  fph_fifo_st_t s_q;
  fph_fifo_st_t s_d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fph_fifo depth must be a power of two");
  end

  assign in_ready_out = s_q.cnt != DEPTH[AW:0];
  assign out_valid_out = s_q.cnt != '0;
  assign out_data_out = s_q.mem[s_q.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_in;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module fph_cmd #(
  parameter int DATA_W = 16,
  parameter int NV_BITS = 3,
  parameter int FIFO_DEPTH = 16,
  parameter int ERASE_CYC = `FPH_ERASE_HOLD_CYC,
  parameter logic [15:0] IFACE_VERSION = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Programmer handshake port
  input wire logic [3:0] hs_mode_in,
  input wire logic [DATA_W-1:0] hs_data_in,
  input wire logic hs_wr_in,
  input wire logic hs_rd_in,
  output logic [DATA_W-1:0] hs_rd_data_out,
  output logic hs_ready_out,
  // Flash controller command port
  output logic flash_cmd_valid_out,
  output logic [7:0] flash_cmd_out,
  output logic [DATA_W-1:0] flash_arg_out,
  output logic flash_ctrl_one_out,
  output logic flush_out,
  // Write stream
  output logic mem_valid_out,
  input wire logic mem_ready_in,
  output logic mem_flash_out,
  output logic [31:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_data_out,
  // Nonvolatile state and erase pin
  output logic [NV_BITS-1:0] nv_config_bit_out,
  output logic secure_out,
  input wire logic erase_pin_in,
  input wire logic test_select_in,
  output logic erase_req_out,
  input wire logic erase_done_in
);
  localparam int FW = 1 + 32 + DATA_W;
  localparam int NPH = 32 / DATA_W;

  typedef struct packed {
    logic [7:0] cmd;
    logic cmd_ok;
    logic [31:0] addr;
    logic [NV_BITS-1:0] nv;
    logic secure;
    logic sel_one;
    logic [DATA_W-1:0] rd_data;
    logic fc_valid;
    logic [7:0] fc_cmd;
    logic [DATA_W-1:0] fc_arg;
    logic flush;
    logic [31:0] er_cnt;
    fph_pkg::fph_erase_t er;
  } fph_st_t;

  fph_st_t s_q;
  fph_st_t s_d;
  logic fifo_valid;
  logic fifo_ready;
  logic [FW-1:0] fifo_data;
  logic [FW-1:0] fifo_out;

  if ((DATA_W != 8 && DATA_W != 16) || NV_BITS < 1 || NV_BITS > DATA_W ||
      ERASE_CYC < 1) begin : g_chk
    $error("fph_cmd needs DATA_W of 8 or 16, 1..DATA_W flag bits, ERASE_CYC of 1 or more");
  end

  function automatic logic [31:0] put_slice(input logic [31:0] a, input int idx,
                                            input logic [DATA_W-1:0] v);
    logic [31:0] r;
    r = a;
    r[idx*DATA_W +: DATA_W] = v;
    return r;
  endfunction

  function automatic logic is_stream(input logic [7:0] op);
    return op == `FPH_OP_MEM_WRITE || op == `FPH_OP_PAGE_WRITE ||
           op == `FPH_OP_PAGE_WRITE_LOCK || op == `FPH_OP_ERASE_PAGE_WRITE ||
           op == `FPH_OP_ERASE_PAGE_WRITE_LOCK;
  endfunction

  always_comb begin
    int ph;
    ph = 0;
    s_d = s_q;
    s_d.rd_data = '0;
    s_d.fc_valid = 1'b0;
    s_d.flush = 1'b0;
    fifo_valid = 1'b0;
    fifo_data = {is_stream(s_q.cmd) && s_q.cmd != `FPH_OP_MEM_WRITE, s_q.addr, hs_data_in};
    if (!s_q.secure && hs_wr_in) begin
      if (hs_mode_in == `FPH_MODE_CMD) begin
        s_d.cmd = hs_data_in[7:0];
        s_d.cmd_ok = 1'b1;
        s_d.flush = 1'b1;
      end else if (s_q.cmd_ok && hs_mode_in >= `FPH_MODE_ADDR_PHASE_0 &&
                   hs_mode_in <= `FPH_MODE_ADDR_PHASE_3) begin
        ph = int'(hs_mode_in - `FPH_MODE_ADDR_PHASE_0);
        if (is_stream(s_q.cmd) && ph < NPH) begin
          s_d.addr = put_slice(s_q.addr, ph, hs_data_in);
        end
      end else if (s_q.cmd_ok && hs_mode_in == `FPH_MODE_DATA) begin
        unique case (s_q.cmd)
          `FPH_OP_SET_NV: begin
            s_d.nv = s_q.nv | hs_data_in[NV_BITS-1:0];
            s_d.fc_valid = 1'b1;
          end
          `FPH_OP_CLEAR_NV: begin
            s_d.nv = s_q.nv & ~hs_data_in[NV_BITS-1:0];
            s_d.fc_valid = 1'b1;
          end
          `FPH_OP_ERASE_ALL: begin
            s_d.nv = '0;
            s_d.fc_valid = 1'b1;
          end
          `FPH_OP_SET_SECURE: begin
            if (hs_data_in == '0 && !s_q.sel_one) begin
              s_d.secure = 1'b1;
              s_d.fc_valid = 1'b1;
            end
          end
          `FPH_OP_PICK_CTRL: begin
            if (hs_data_in == `FPH_SEL_ZERO) begin
              s_d.sel_one = 1'b0;
            end else if (hs_data_in == `FPH_SEL_ONE) begin
              s_d.sel_one = 1'b1;
            end
          end
          `FPH_OP_SET_LOCK, `FPH_OP_CLEAR_LOCK: begin
            s_d.fc_valid = 1'b1;
          end
          default: begin
            if (is_stream(s_q.cmd) && fifo_ready) begin
              fifo_valid = 1'b1;
              s_d.addr = s_q.addr + 32'(DATA_W / 8);
            end
          end
        endcase
        s_d.fc_cmd = s_q.cmd;
        s_d.fc_arg = hs_data_in;
      end
    end
    if (!s_q.secure && hs_rd_in && s_q.cmd_ok && hs_mode_in == `FPH_MODE_DATA) begin
      if (s_q.cmd == `FPH_OP_GET_NV) begin
        s_d.rd_data = DATA_W'(s_q.nv);
      end else if (s_q.cmd == `FPH_OP_GET_VERSION) begin
        s_d.rd_data = IFACE_VERSION[DATA_W-1:0];
      end
    end
    unique case (s_q.er)
      fph_pkg::FPH_ER_IDLE: begin
        s_d.er_cnt = '0;
        if (erase_pin_in && !test_select_in) begin
          s_d.er = fph_pkg::FPH_ER_HOLD;
        end
      end
      fph_pkg::FPH_ER_HOLD: begin
        if (!erase_pin_in || test_select_in) begin
          s_d.er = fph_pkg::FPH_ER_IDLE;
        end else if (s_q.er_cnt >= 32'(ERASE_CYC - 1)) begin
          s_d.er = fph_pkg::FPH_ER_WAIT;
        end else begin
          s_d.er_cnt = s_q.er_cnt + 32'd1;
        end
      end
      fph_pkg::FPH_ER_WAIT: begin
        if (erase_done_in) begin
          s_d.secure = 1'b0;
          s_d.nv = '0;
          s_d.er = fph_pkg::FPH_ER_IDLE;
        end
      end
      default: begin
        s_d.er = fph_pkg::FPH_ER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.er <= fph_pkg::FPH_ER_IDLE;
      s_q.sel_one <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  fph_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(fifo_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(fifo_data),
    .out_valid_out(mem_valid_out),
    .out_ready_in(mem_ready_in),
    .out_data_out(fifo_out)
  );

  assign mem_flash_out = fifo_out[FW-1];
  assign mem_addr_out = fifo_out[FW-2 -: 32];
  assign mem_data_out = fifo_out[DATA_W-1:0];
  assign hs_rd_data_out = s_q.rd_data;
  assign hs_ready_out = fifo_ready && !s_q.secure;
  assign flash_cmd_valid_out = s_q.fc_valid;
  assign flash_cmd_out = s_q.fc_cmd;
  assign flash_arg_out = s_q.fc_arg;
  assign flash_ctrl_one_out = s_q.sel_one;
  assign flush_out = s_q.flush;
  assign nv_config_bit_out = s_q.nv;
  assign secure_out = s_q.secure;
  assign erase_req_out = s_q.er == fph_pkg::FPH_ER_WAIT;
endmodule

// ### sim/fph_sink.sv
// Stream sink and flash erase responder
`timescale 1ns/100ps
module fph_sink (
  // Stream side
  input wire logic clock_in,
  input wire logic valid_in,
  input wire logic [48:0] word_in,
  input wire logic stall_in,
  output logic ready_out = 1'b0,
  // Erase side
  input wire logic erase_req_in,
  output logic erase_done_out = 1'b0
);
  logic [48:0] got_q[$];
  int seed = 32'ha43a30c8;
  int n = 0;
  always @(posedge clock_in) begin
    if (valid_in && ready_out) got_q.push_back(word_in);
    ready_out <= !stall_in && $random(seed) % 3 != 0;
    n <= erase_req_in ? n + 1 : 0;
    erase_done_out <= erase_req_in && n == 4;
  end
endmodule

// ### sim/fph_cmd_chk.sv
// Port assertions for the command handler
`timescale 1ns/100ps
`include "fph_defines.svh"
module fph_cmd_chk #(
  parameter int DATA_W = 16,
  parameter int NV_BITS = 3,
  parameter logic [15:0] IFACE_VERSION = 16'h0001
) (
  // Clock, reset, handshake
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [3:0] hs_mode_in,
  input wire logic [DATA_W-1:0] hs_data_in,
  input wire logic hs_wr_in,
  input wire logic hs_rd_in,
  input wire logic [DATA_W-1:0] hs_rd_data_out,
  // State
  input wire logic flush_out,
  input wire logic [NV_BITS-1:0] nv_config_bit_out,
  input wire logic secure_out,
  input wire logic erase_req_out,
  input wire logic erase_done_in
);
  logic [7:0] op_q;
  logic dw, rw, cw;
  logic [NV_BITS-1:0] nv, m;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  assign nv = nv_config_bit_out;
  assign m = hs_data_in[NV_BITS-1:0];
  assign cw = hs_wr_in && hs_mode_in == `FPH_MODE_CMD && !secure_out;
  assign dw = hs_wr_in && hs_mode_in == `FPH_MODE_DATA && !secure_out;
  assign rw = hs_rd_in && hs_mode_in == `FPH_MODE_DATA && !secure_out;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) op_q <= 8'h00;
    else if (cw) op_q <= hs_data_in[7:0];
  end
  AST_SET: assert property (dw && op_q == `FPH_OP_SET_NV |=> nv == ($past(nv) | $past(m)))
    else $error("set mask not applied");
  AST_CLR: assert property (dw && op_q == `FPH_OP_CLEAR_NV |=> nv == ($past(nv) & ~$past(m)))
    else $error("clear mask not applied");
  AST_EA: assert property (dw && op_q == `FPH_OP_ERASE_ALL |=> nv == '0)
    else $error("erase all kept bits");
  AST_GET: assert property (rw && op_q == `FPH_OP_GET_NV |=> hs_rd_data_out == DATA_W'($past(nv)))
    else $error("bad flag read");
  AST_VER: assert property (rw && op_q == `FPH_OP_GET_VERSION
    |=> hs_rd_data_out == IFACE_VERSION[DATA_W-1:0]) else $error("bad version");
  AST_LOCK: assert property (secure_out && !erase_done_in |=> secure_out && $stable(nv))
    else $error("secure state left");
  AST_UNLOCK: assert property (erase_req_out && erase_done_in |=> !secure_out && nv == '0)
    else $error("erase did not unlock");
  AST_FLUSH: assert property (cw |=> flush_out)
    else $error("no flush after command");
  AST_SEC_FLUSH: assert property (secure_out && hs_wr_in |=> !flush_out)
    else $error("command taken while secure");
  cover property (rw && op_q == `FPH_OP_GET_NV);
  cover property (secure_out && hs_wr_in);
  cover property (erase_req_out && erase_done_in);
endmodule
bind fph_cmd fph_cmd_chk #(.DATA_W(DATA_W), .NV_BITS(NV_BITS), .IFACE_VERSION(IFACE_VERSION))
  fph_cmd_chk_inst (.clock_in, .rst_b_in, .hs_mode_in, .hs_data_in, .hs_wr_in, .hs_rd_in,
  .hs_rd_data_out, .flush_out, .nv_config_bit_out, .secure_out, .erase_req_out, .erase_done_in);

// ### sim/fph_cmd_tb.sv
// Self-checking bench for the command handler
`timescale 1ns/100ps
`include "fph_defines.svh"
module fph_cmd_tb;
  localparam logic [15:0] VER = 16'h5a3c; // Arbitrary value
  logic clock_in = 0, rst_b_in = 0, hs_wr_in = 0, hs_rd_in = 0, stall = 0;
  logic erase_pin_in = 0, test_select_in = 0, mem_ready_in, erase_done_in;
  logic hs_ready_out, flash_cmd_valid_out, flash_ctrl_one_out, flush_out, mem_valid_out;
  logic mem_flash_out, secure_out, erase_req_out;
  logic [3:0] hs_mode_in = 0;
  logic [15:0] hs_data_in = 0, hs_rd_data_out, flash_arg_out, mem_data_out, v;
  logic [7:0] flash_cmd_out;
  logic [31:0] mem_addr_out, a;
  logic [2:0] nv_config_bit_out, nv_m = 0;
  logic [48:0] exp_q[$];
  int num_errors = 0, num_checks = 0, seed = 32'ha43a30c8;
  initial forever #4 clock_in = !clock_in;
  fph_cmd #(.ERASE_CYC(10), .IFACE_VERSION(VER)) fph_cmd_inst (.clock_in, .rst_b_in,
    .hs_mode_in, .hs_data_in, .hs_wr_in, .hs_rd_in, .hs_rd_data_out, .hs_ready_out,
    .flash_cmd_valid_out, .flash_cmd_out, .flash_arg_out, .flash_ctrl_one_out, .flush_out,
    .mem_valid_out, .mem_ready_in, .mem_flash_out, .mem_addr_out, .mem_data_out,
    .nv_config_bit_out, .secure_out, .erase_pin_in, .test_select_in, .erase_req_out,
    .erase_done_in);
  fph_sink fph_sink_inst (.clock_in, .valid_in(mem_valid_out), .word_in({mem_flash_out, mem_addr_out,
    mem_data_out}), .stall_in(stall), .ready_out(mem_ready_in), .erase_req_in(erase_req_out),
    .erase_done_out(erase_done_in));
  function automatic logic [2:0] nv_next(logic s, logic [2:0] o, logic [2:0] k);
    return s ? o | k : o & ~k;
  endfunction
  task automatic chk(input string n, input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic put(input logic [3:0] md, input logic [15:0] d);
    hs_mode_in <= md;
    hs_data_in <= d;
    hs_wr_in <= 1;
    hs_rd_in <= 0;
    @(posedge clock_in);
  endtask
  task automatic idle();
    hs_wr_in <= 0;
    @(posedge clock_in);
  endtask
  task automatic get(input logic [7:0] op);
    put(`FPH_MODE_CMD, {8'h00, op});
    hs_mode_in <= `FPH_MODE_DATA;
    hs_wr_in <= 0;
    hs_rd_in <= 1;
    @(posedge clock_in);
    hs_rd_in <= 0;
    @(negedge clock_in);
    v = hs_rd_data_out;
    @(posedge clock_in);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] d);
    put(`FPH_MODE_CMD, {8'h00, op});
    put(`FPH_MODE_DATA, d);
    idle();
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    rst_b_in <= 1;
    put(`FPH_MODE_DATA, 16'h0007);
    idle();
    chk("init", {flash_ctrl_one_out, nv_config_bit_out}, 0);
    repeat (12) begin
      a = $random(seed);
      cmd(a[15] ? `FPH_OP_SET_NV : `FPH_OP_CLEAR_NV, a[15:0]);
      nv_m = nv_next(a[15], nv_m, a[2:0]);
      chk("nv", nv_config_bit_out, nv_m);
      get(`FPH_OP_GET_NV);
      chk("get", v, nv_m);
    end
    get(`FPH_OP_GET_VERSION);
    chk("ver", v, VER);
    cmd(`FPH_OP_SET_NV, 16'h0005);
    cmd(`FPH_OP_PICK_CTRL, `FPH_SEL_ONE);
    cmd(`FPH_OP_ERASE_ALL, 16'h0000);
    chk("ea", {flash_cmd_out, flash_ctrl_one_out, nv_config_bit_out}, 12'h088);
    chk("ea_cmd", {flash_cmd_valid_out, flash_arg_out}, 17'h10000);
    cmd(`FPH_OP_SET_LOCK, 16'h0003);
    chk("lock_cmd", {flash_cmd_valid_out, flash_cmd_out}, {1'b1, `FPH_OP_SET_LOCK});
    chk("lock_arg", {flash_arg_out, flash_ctrl_one_out}, 17'h00007);
    cmd(`FPH_OP_PICK_CTRL, `FPH_SEL_ZERO);
    chk("pick", {flash_cmd_valid_out, flash_ctrl_one_out}, 0);
    stall <= 1;
    a = $random(seed);
    put(`FPH_MODE_CMD, {8'h00, `FPH_OP_MEM_WRITE});
    put(`FPH_MODE_ADDR_PHASE_0, a[15:0]);
    put(`FPH_MODE_ADDR_PHASE_1, a[31:16]);
    for (int i = 0; i < 17; i++) begin
      v = $random(seed);
      put(`FPH_MODE_DATA, v);
      if (i < 16) exp_q.push_back({1'b0, a + 32'(2 * i), v});
    end
    idle();
    chk("full", hs_ready_out, 0);
    stall <= 0;
    a = a + 32'h100;
    put(`FPH_MODE_ADDR_PHASE_0, a[15:0]);
    put(`FPH_MODE_ADDR_PHASE_1, a[31:16]);
    for (int i = 0; i < 50 && !hs_ready_out; i++) idle();
    chk("room", hs_ready_out, 1);
    put(`FPH_MODE_DATA, v);
    exp_q.push_back({1'b0, a, v});
    idle();
    for (int i = 0; i < 300 && fph_sink_inst.got_q.size() < 17; i++) @(posedge clock_in);
    chk("cnt", fph_sink_inst.got_q.size(), 17);
    if (fph_sink_inst.got_q.size() == 17)
    foreach (exp_q[i]) chk("word", fph_sink_inst.got_q[i], exp_q[i]);
    a = $random(seed);
    put(`FPH_MODE_CMD, {8'h00, `FPH_OP_PAGE_WRITE});
    put(`FPH_MODE_ADDR_PHASE_0, a[15:0]);
    put(`FPH_MODE_ADDR_PHASE_1, a[31:16]);
    put(`FPH_MODE_DATA, a[15:0]);
    idle();
    for (int i = 0; i < 50 && fph_sink_inst.got_q.size() < 18; i++) @(posedge clock_in);
    chk("page", fph_sink_inst.got_q[17], {1'b1, a, a[15:0]});
    cmd(`FPH_OP_SET_SECURE, 16'h0000);
    cmd(`FPH_OP_SET_NV, 16'h0007);
    chk("lock", {secure_out, hs_ready_out, nv_config_bit_out}, 5'h10);
    chk("chain", fph_sink_inst.got_q.size(), 18);
    test_select_in <= 1;
    erase_pin_in <= 1;
    repeat (20) @(posedge clock_in);
    chk("tst", {erase_req_out, secure_out}, 2'b01);
    test_select_in <= 0;
    erase_pin_in <= 1;
    for (int i = 0; i < 40 && !erase_req_out; i++) @(posedge clock_in);
    chk("req", {erase_req_out, secure_out}, 2'b11);
    for (int i = 0; i < 40 && secure_out; i++) @(posedge clock_in);
    erase_pin_in <= 0;
    chk("unsec", {secure_out, nv_config_bit_out}, 0);
    end_sim();
  end
endmodule
